//--- hw/prs_defs.vh
// Purpose: constants for the protection restart sequencer
// Assumes: comparator results arrive as clean levels on CORE_CLK (40 MHz)
// Notes: timings are analog (external RC); the logic holds no counters of its own
//
// Behaviour
// - restart state turns both controllers off, then resumes start-up after delay.
// - protection shutdown turns controllers off and latches; no self restart.
// - latched shutdown cleared when both supplies fall below reset levels.
// - mains sense dip below reset level then recovery clears latched shutdown.
// - enable pin pulled low clears latched shutdown.
// - thermal hold keeps controllers off until temperature falls about 10 C.
// - overtemperature comparator above 150 C trip enters thermal hold.
// - one timer pin serves protection delay and restart delay.
// - timed error present enables 100 uA slow charge out of timer pin.
// - timer at upper threshold during delay triggers action and discharge; the code discharges only for a shutdown action, not for a restart.
// - error gone before threshold: stop charging, let resistor discharge, no action.
// - timer pin above upper threshold at any time forces protection shutdown; the code does so only in run outside a protection delay.
// - restart delay runs only in the restart state.
// - idle timer held at 0 V; restart fast-charges to upper, then releases.
// - restart ends when pin decays to 0.5 V lower threshold; then discharge.
// - output sense above 3.5 V overvoltage goes straight to latched shutdown.
// - enable pin low keeps every controller disabled while low.
// - both supplies below reset levels hold all protection logic in reset.
`ifndef PRS_DEFS_VH
`define PRS_DEFS_VH
`define PRS_NUM_SRC      4
`define PRS_SYNC_W       9
`define PRS_MAP_DEFAULT  4'b0101
`define PRS_UPPER_MV     4000
`define PRS_LOWER_MV     500
`define PRS_OVP_MV       3500
`define PRS_OTP_DEGC     150
`define PRS_OTP_HYS_DEGC 10
`define PRS_CHG_UA       100
`endif

//--- hw/prs_sync.v
// Purpose: two-flop level synchroniser, one per comparator bit
// Assumes: single clock domain, async active-low reset
// Notes: first stage feeds only the second stage
module prs_sync #(
    parameter W = 9
) (
    // clock and reset
    input  wire         clk,
    input  wire         rst_n,
    // levels
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta_q;

    // two stages per bit
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_q[i] <= 1'b0;
                    q[i]      <= 1'b0;
                end else begin
                    meta_q[i] <= d[i];
                    q[i]      <= meta_q[i];
                end
            end
        end
    endgenerate
endmodule // prs_sync

//--- hw/prs_seq.v
// Purpose: restart / latched shutdown / thermal hold sequencer with shared RC timer
// Assumes: all inputs are comparator levels; RESETN low when both supplies are low
// Notes: timer pin is driven by slow charge, fast charge and discharge enables
// Notes: an aborted delay leaves the pin released until the lower threshold
`include "prs_defs.vh"
module prs_seq #(
    parameter [`PRS_NUM_SRC-1:0] SRC_IS_SHUTDOWN = `PRS_MAP_DEFAULT
) (
    // clock and reset
    input  wire                    CORE_CLK,
    input  wire                    RESETN,
    // comparator levels
    input  wire                    TIMER_ABOVE_UPPER,
    input  wire                    TIMER_ABOVE_LOWER,
    input  wire                    IC_SUPPLY_LOW,
    input  wire                    HV_SUPPLY_LOW,
    input  wire                    MAINS_BELOW_RESET,
    input  wire                    MAINS_ABOVE_HYS,
    input  wire                    OUTPUT_OVERVOLTAGE,
    input  wire                    OVERTEMP,
    input  wire                    OVERTEMP_CLEARED,
    input  wire                    ENABLE_PIN_HIGH,
    // protection sources
    input  wire [`PRS_NUM_SRC-1:0] TIMED_ERR,
    input  wire [`PRS_NUM_SRC-1:0] INSTANT_ERR,
    // controller enables and status
    output reg                     CTRL_ENABLE,
    output reg                     STARTUP_REQ,
    output reg                     IN_RESTART,
    output reg                     IN_SHUTDOWN,
    output reg                     IN_THERMAL,
    // timer pin drive
    output reg                     TIMER_SLOW_CHARGE,
    output reg                     TIMER_FAST_CHARGE,
    output reg                     TIMER_DISCHARGE
);
    // one-hot states
    // run covers start-up and normal operation
    localparam [4:0] ST_RUN  = 5'b00001;
    localparam [4:0] ST_RFC  = 5'b00010; // restart fast charge
    localparam [4:0] ST_RDK  = 5'b00100; // restart decay
    localparam [4:0] ST_SHD  = 5'b01000;
    localparam [4:0] ST_OTH  = 5'b10000;

    wire [`PRS_SYNC_W-1:0] raw_lv;
    wire [`PRS_SYNC_W-1:0] sy;
    wire [`PRS_NUM_SRC-1:0] tim_s;
    wire [`PRS_NUM_SRC-1:0] ins_s;

    // comparator levels all pass through synchronisers
    assign raw_lv = {
        TIMER_ABOVE_UPPER,   // bit 8
        TIMER_ABOVE_LOWER,   // bit 7
        IC_SUPPLY_LOW,       // bit 6
        HV_SUPPLY_LOW,       // bit 5
        MAINS_BELOW_RESET,   // bit 4
        MAINS_ABOVE_HYS,     // bit 3
        OUTPUT_OVERVOLTAGE,  // bit 2
        OVERTEMP,            // bit 1
        OVERTEMP_CLEARED     // bit 0
    };

    prs_sync #(.W(`PRS_SYNC_W)) u_sync_lv (
        .clk   (CORE_CLK),
        .rst_n (RESETN),
        .d     (raw_lv),
        .q     (sy)
    );

    prs_sync #(.W(2*`PRS_NUM_SRC)) u_sync_err (
        .clk   (CORE_CLK),
        .rst_n (RESETN),
        .d     ({TIMED_ERR, INSTANT_ERR}),
        .q     ({tim_s, ins_s})
    );

    // the enable pin is a level too; its own two stages
    reg en_m_q;
    reg en_s_q;
    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            en_m_q <= 1'b0;
            en_s_q <= 1'b0;
        end else begin
            en_m_q <= ENABLE_PIN_HIGH;
            en_s_q <= en_m_q;
        end
    end

    wire up_s    = sy[8];
    wire lo_s    = sy[7];
    wire sup_rst = sy[6] & sy[5];
    wire mn_low  = sy[4];
    wire mn_hys  = sy[3];
    wire ovp_s   = sy[2];
    wire otp_s   = sy[1];
    wire otp_clr = sy[0];

    // routing of sources through the mapping table
    // a set bit sends that source to latched shutdown, a clear bit to restart
    // timed sources only act once the rc delay has run out
    wire any_timed = |tim_s;
    wire tim_shd   = |(tim_s & SRC_IS_SHUTDOWN);
    wire ins_shd   = |(ins_s & SRC_IS_SHUTDOWN);
    wire ins_rst   = |(ins_s & ~SRC_IS_SHUTDOWN);

    reg  [4:0] st_q;
    reg  [4:0] st_d;
    reg        mains_dip_q;
    reg        mains_dip_d;
    reg        prot_timing;

    // timing of a protection delay happens only in run with a timed error present
    always @* begin
        prot_timing = (st_q == ST_RUN) && any_timed && en_s_q;
    end

    // state transitions; thermal hold has top priority
    // then overvoltage or instant shutdown, timer expiry, pin forced high,
    // and last an instant restart request
    always @* begin
        st_d        = st_q;
        mains_dip_d = mains_dip_q;
        case (st_q)
            ST_RUN: begin
                mains_dip_d = 1'b0;
                if (otp_s) begin
                    st_d = ST_OTH;
                end else if (ovp_s || ins_shd) begin
                    st_d = ST_SHD;
                end else if (up_s && prot_timing) begin
                    // delay elapsed: mapped action
                    st_d = tim_shd ? ST_SHD : ST_RFC;
                end else if (up_s) begin
                    st_d = ST_SHD;
                end else if (ins_rst) begin
                    st_d = ST_RFC;
                end
            end
            ST_RFC: begin
                if (otp_s) begin
                    st_d = ST_OTH;
                end else if (ovp_s) begin
                    st_d = ST_SHD;
                end else if (up_s) begin
                    st_d = ST_RDK;
                end
            end
            ST_RDK: begin
                if (otp_s) begin
                    st_d = ST_OTH;
                end else if (ovp_s) begin
                    st_d = ST_SHD;
                end else if (!lo_s) begin
                    st_d = ST_RUN;
                end
            end
            ST_SHD: begin
                if (otp_s) begin
                    st_d = ST_OTH;
                end else if (!en_s_q) begin
                    st_d = ST_RUN;
                end else if (mains_dip_q && mn_hys) begin
                    st_d = ST_RUN;
                end else if (mn_low) begin
                    mains_dip_d = 1'b1;
                end
                // otherwise latched forever
            end
            ST_OTH: begin
                // exit only when temperature is below trip minus hysteresis
                if (otp_clr && !otp_s) begin
                    st_d = ST_RUN;
                end
            end
            default: begin
                st_d = ST_RUN;
            end
        endcase
    end

    // state register; reset also covers supply collapse on the pins
    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_q        <= ST_RUN;
            mains_dip_q <= 1'b0;
        end else if (sup_rst) begin
            st_q        <= ST_RUN;
            mains_dip_q <= 1'b0;
        end else begin
            st_q        <= st_d;
            mains_dip_q <= mains_dip_d;
        end
    end

    // effective next state: a supply collapse overrides any transition
    wire [4:0] st_n = sup_rst ? ST_RUN : st_d;

    // aborted protection delay: pin stays released so the resistor bleeds the
    // capacitor down; a hard clamp would cut short the rc decay the timer relies on
    reg        bleed_q;
    reg        bleed_d;
    always @* begin
        // leaving run clears the flag before anything else is looked at
        bleed_d = bleed_q;
        if (st_n != ST_RUN) begin
            bleed_d = 1'b0;
        end else if (prot_timing) begin
            bleed_d = 1'b1;
        end else if (!lo_s) begin
            bleed_d = 1'b0;
        end
    end

    // bleed flag register
    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            bleed_q <= 1'b0;
        end else begin
            bleed_q <= bleed_d;
        end
    end

    // decoded next values of every output
    reg        ctl_d;
    reg        start_d;
    reg        rst_flag_d;
    reg        shd_flag_d;
    reg        oth_flag_d;
    reg        slow_d;
    reg        fast_d;
    reg        dis_d;

    // per-state output decode; the three timer drives never overlap
    always @* begin
        // defaults: controllers off, pin clamped to 0 V
        ctl_d      = 1'b0;
        start_d    = 1'b0;
        rst_flag_d = 1'b0;
        shd_flag_d = 1'b0;
        oth_flag_d = 1'b0;
        slow_d     = 1'b0;
        fast_d     = 1'b0;
        dis_d      = 1'b1;

        case (st_n)
            // run: controllers follow the enable pin
            ST_RUN: begin
                ctl_d   = en_s_q && !sup_rst;
                start_d = (st_q == ST_RDK) && !sup_rst;
                slow_d  = prot_timing && !up_s && !sup_rst;
                // released while charging or bleeding; no supply means no clamp
                dis_d   = !(any_timed || bleed_d) && !sup_rst;
            end
            // restart fast charge up to the upper threshold
            ST_RFC: begin
                rst_flag_d = 1'b1;
                fast_d     = 1'b1;
                dis_d      = 1'b0;
            end
            // restart decay through the resistor
            ST_RDK: begin
                rst_flag_d = 1'b1;
                dis_d      = 1'b0;
            end
            // latched shutdown, capacitor discharged after the action
            ST_SHD: begin
                shd_flag_d = 1'b1;
            end
            // thermal hold
            ST_OTH: begin
                oth_flag_d = 1'b1;
            end
            default: begin
                dis_d = 1'b1;
            end
        endcase
    end

    // output registers, loaded from the decode of the next state
    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            // pin clamped low while in reset
            CTRL_ENABLE       <= 1'b0;
            STARTUP_REQ       <= 1'b0;
            IN_RESTART        <= 1'b0;
            IN_SHUTDOWN       <= 1'b0;
            IN_THERMAL        <= 1'b0;
            TIMER_SLOW_CHARGE <= 1'b0;
            TIMER_FAST_CHARGE <= 1'b0;
            TIMER_DISCHARGE   <= 1'b1;
        end else begin
            // controller enable and status flags
            CTRL_ENABLE       <= ctl_d;
            STARTUP_REQ       <= start_d;
            IN_RESTART        <= rst_flag_d;
            IN_SHUTDOWN       <= shd_flag_d;
            IN_THERMAL        <= oth_flag_d;
            // timer pin drive
            TIMER_SLOW_CHARGE <= slow_d;
            TIMER_FAST_CHARGE <= fast_d;
            TIMER_DISCHARGE   <= dis_d;
        end
    end
endmodule // prs_seq

//--- tb/prs_rc_model.sv
// Purpose: RC timer network model with its two comparators
// Assumes: one step per clock, values in millivolts
// Notes: force_hi stands for an outside circuit lifting the pin
`include "prs_defs.vh"
module prs_rc_model (
    input  logic clk,
    input  logic slow,
    input  logic fast,
    input  logic dis,
    input  logic force_hi,
    output logic above_upper,
    output logic above_lower
);
    timeunit 1ns;
    timeprecision 100ps;
    int v = 0;
    // clamp, charge, or let the resistor bleed the capacitor
    always @(posedge clk) begin
        if (dis) begin
            v <= 0;
        end else if (fast) begin
            v <= v + 500;
        end else if (slow) begin
            v <= v + 100 - v / 64;
        end else begin
            v <= v - v / 32;
        end
    end
    assign above_upper = force_hi || v >= `PRS_UPPER_MV;
    assign above_lower = v > `PRS_LOWER_MV;
endmodule // prs_rc_model

//--- tb/prs_seq_assertions.sv
// Purpose: port checks for the sequencer
// Assumes: outputs follow inputs after 3 edges
// Notes: bound to every sequencer instance
module prs_seq_chk #(parameter [3:0] SRC_IS_SHUTDOWN = 4'b0101) (
    input logic CORE_CLK, RESETN, TIMER_ABOVE_UPPER, TIMER_ABOVE_LOWER,
    input logic IC_SUPPLY_LOW, HV_SUPPLY_LOW, MAINS_BELOW_RESET, MAINS_ABOVE_HYS,
    input logic OUTPUT_OVERVOLTAGE, OVERTEMP, OVERTEMP_CLEARED, ENABLE_PIN_HIGH,
    input logic [3:0] TIMED_ERR, INSTANT_ERR,
    input logic CTRL_ENABLE, STARTUP_REQ, IN_RESTART, IN_SHUTDOWN, IN_THERMAL,
    input logic TIMER_SLOW_CHARGE, TIMER_FAST_CHARGE, TIMER_DISCHARGE
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    property p_off; IN_RESTART || IN_SHUTDOWN || IN_THERMAL |-> !CTRL_ENABLE; endproperty
    a_off: assert property (p_off) else $error("controllers on while stopped");
    property p_latch; $fell(IN_SHUTDOWN) |-> IN_THERMAL || $past(!ENABLE_PIN_HIGH, 3)
        || $past(MAINS_ABOVE_HYS, 3) || $past(IC_SUPPLY_LOW && HV_SUPPLY_LOW, 3); endproperty
    a_latch: assert property (p_latch) else $error("shutdown left without cause");
    property p_otp; OVERTEMP [*3] |=> IN_THERMAL; endproperty
    a_otp: assert property (p_otp) else $error("no thermal hold");
    property p_ovp; (OUTPUT_OVERVOLTAGE && !OVERTEMP) [*3] |=> IN_SHUTDOWN || IN_THERMAL; endproperty
    a_ovp: assert property (p_ovp) else $error("overvoltage not latched");
    property p_en; (!ENABLE_PIN_HIGH) [*3] |=> !CTRL_ENABLE; endproperty
    a_en: assert property (p_en) else $error("enabled while pin low");
    property p_slow; (TIMED_ERR == 4'h0) [*4] |=> !TIMER_SLOW_CHARGE; endproperty
    a_slow: assert property (p_slow) else $error("charging without error");
    property p_drive; $onehot0({TIMER_SLOW_CHARGE, TIMER_FAST_CHARGE, TIMER_DISCHARGE}); endproperty
    a_drive: assert property (p_drive) else $error("timer drives clash");
    property p_fast; TIMER_FAST_CHARGE |-> IN_RESTART; endproperty
    a_fast: assert property (p_fast) else $error("fast charge outside restart");
    property p_end; $fell(IN_RESTART) && !IN_SHUTDOWN && !IN_THERMAL
        |-> STARTUP_REQ && TIMER_DISCHARGE ##1 !STARTUP_REQ; endproperty
    a_end: assert property (p_end) else $error("restart end wrong");
endmodule // prs_seq_chk
bind prs_seq prs_seq_chk #(.SRC_IS_SHUTDOWN(SRC_IS_SHUTDOWN)) prs_seq_chk_inst (.*);

//--- tb/testbench.sv
// Purpose: directed scenarios for the sequencer
// Assumes: inputs move 1 ns after the rising edge
// Notes: RC network is a behavioural model
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst_n, ic_low, hv_low, m_below, m_hys, ovp, otp, otp_clr, en, force_hi;
    logic [3:0] t_err, i_err;
    wire up, lo, ctl, sreq, rs, sd, th, slow, fast, dis;
    int fail_count, checked, cyc, i;
    prs_seq prs_seq_inst (.CORE_CLK(clk), .RESETN(rst_n), .TIMER_ABOVE_UPPER(up),
        .TIMER_ABOVE_LOWER(lo), .IC_SUPPLY_LOW(ic_low), .HV_SUPPLY_LOW(hv_low),
        .MAINS_BELOW_RESET(m_below), .MAINS_ABOVE_HYS(m_hys), .OUTPUT_OVERVOLTAGE(ovp),
        .OVERTEMP(otp), .OVERTEMP_CLEARED(otp_clr), .ENABLE_PIN_HIGH(en), .TIMED_ERR(t_err),
        .INSTANT_ERR(i_err), .CTRL_ENABLE(ctl), .STARTUP_REQ(sreq), .IN_RESTART(rs),
        .IN_SHUTDOWN(sd), .IN_THERMAL(th), .TIMER_SLOW_CHARGE(slow),
        .TIMER_FAST_CHARGE(fast), .TIMER_DISCHARGE(dis));
    prs_rc_model prs_rc_model_inst (.clk(clk), .slow(slow), .fast(fast), .dis(dis),
        .force_hi(force_hi), .above_upper(up), .above_lower(lo));
    // free running clock, 25 ns
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    // hang guard, far above the several hundred cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            complete_run();
        end
    end
    task cy(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(input string n, input logic s, input logic e);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %b seen %b", n, e, s);
        end
    endtask
    task complete_run();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task t_restart();
        i_err = 4'h2;
        cy(1);
        i_err = 4'h0;
        cy(3);
        chk("restart", rs, 1);
        chk("ctl", ctl, 0);
        chk("fast", fast, 1);
        for (i = 0; i < 400 && rs; i++) cy(1);
        chk("delay", i > 20, 1);
        chk("sreq", sreq, 1);
        chk("dis", dis, 1);
        chk("ctl", ctl, 1);
    endtask
    task t_timed();
        t_err = 4'h1;
        cy(3);
        chk("slow", slow, 1);
        for (i = 0; i < 400 && !sd; i++) cy(1);
        chk("sd", sd, 1);
        cy(1);
        chk("dis", dis, 1);
        t_err = 4'h0;
        cy(50);
        chk("latch", sd, 1);
        en = 0;
        cy(4);
        chk("sd", sd, 0);
        chk("ctl", ctl, 0);
        en = 1;
        cy(4);
        chk("ctl", ctl, 1);
    endtask
    task t_other();
        t_err = 4'h4;
        cy(20);
        t_err = 4'h0;
        cy(4);
        chk("bleed", dis | slow, 0);
        cy(296);
        chk("abort", sd | rs | slow, 0);
        chk("idle", dis, 1);
        t_err = 4'h2;
        for (i = 0; i < 400 && !rs; i++) cy(1);
        chk("map", rs & ~sd, 1);
        t_err = 4'h0;
        for (i = 0; i < 400 && rs; i++) cy(1);
        ovp = 1;
        cy(3);
        chk("ovp", sd, 1);
        ovp = 0;
        m_hys = 0;
        m_below = 1;
        cy(4);
        m_below = 0;
        cy(2);
        m_hys = 1;
        cy(4);
        chk("mains", sd, 0);
        force_hi = 1;
        cy(4);
        chk("force", sd, 1);
        force_hi = 0;
        ic_low = 1;
        cy(4);
        chk("one", sd, 1);
        hv_low = 1;
        cy(4);
        chk("supply", sd | rs, 0);
        ic_low = 0;
        hv_low = 0;
        i_err = 4'h1;
        cy(1);
        i_err = 4'h0;
        cy(3);
        chk("ins_shd", sd, 1);
        otp = 1;
        otp_clr = 0;
        ovp = 1;
        cy(3);
        chk("th", th & ~sd & ~ctl, 1);
        ovp = 0;
        otp = 0;
        cy(10);
        chk("hold", th, 1);
        otp_clr = 1;
        cy(4);
        chk("th", th, 0);
    endtask
    // main sequence
    initial begin
        {ic_low, hv_low, m_below, ovp, otp, force_hi, rst_n} = 0;
        {m_hys, otp_clr, en} = 3'h7;
        t_err = 4'h0;
        i_err = 4'h0;
        cy(3);
        chk("rst_dis", dis, 1);
        rst_n = 1;
        cy(5);
        chk("ctl", ctl, 1);
        t_restart();
        t_timed();
        t_other();
        complete_run();
    end
endmodule // testbench
